// File: include/bpr_pkg.sv
// Constants and types shared by the bidirectional parity register and its FIFO.
package bpr_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int DATA_W     = 8;
  localparam int WORD_W     = 9;
  localparam int PAR_BIT    = 8;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================================
  // Encodings and reset values
  localparam logic               SENSE_EVEN     = 1'b0;
  localparam logic               SEL_LATCH_PATH = 1'b0;
  localparam logic [WORD_W-1:0]  WORD_RST       = 9'h000;

  // One-hot choice of the port-B-to-port-A data path.
  typedef enum logic [1:0] {
    BPR_PATH_LATCH = 2'b01,
    BPR_PATH_PIPE  = 2'b10
  } bpr_path_t;

endpackage

// File: core/bpr_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module bpr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      count_q, count_d;
  logic             inReady_q, inReady_d;
  logic             push, pop;

  // ==========================================================================
  // Pointer and count control
  // Ready is registered so the source sees a clean flop; it is computed from
  // the next count, so a pop in the same cycle as full reopens at once.
  always_comb begin
    push      = inValid && inReady_q;
    pop       = outValid && outReady;
    wrPtr_d   = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d   = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d   = (AW+1)'(count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    inReady_d = (count_d != FULL_CNT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      count_q   <= '0;
      inReady_q <= 1'b0;
    end else begin
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      count_q   <= count_d;
      inReady_q <= inReady_d;
    end
  end

  // Storage array; no reset needed since reads are gated by the count.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  assign inReady  = inReady_q;
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];

  // ==========================================================================
  // Checks
  chk_fifo_full_stall: assert property (@(posedge clk) disable iff (rst)
    (count_q == FULL_CNT) |-> !inReady)
    else $error("FIFO offers ready while full.");
  chk_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
    count_q <= FULL_CNT)
    else $error("FIFO count exceeds depth.");
  cov_fifo_full: cover property (@(posedge clk) disable iff (rst) count_q == FULL_CNT);
endmodule

// File: core/bpr_core.sv
// Bidirectional registered transceiver with ninth parity bit on both ports.
// Operation
// - One clock, per-direction clock and output enables.
// - Directions load and drive independently.
// - A-to-B holding register captures nine bits.
// - Parity sense picks even or odd generation.
// - A-to-B even check raises port-A error.
// - Port B driven only while its enable.
// - Path select muxes two B-to-A paths.
// - Both B-to-A paths even-checked, port-B error.
// - Latch path; ninth bit flipped by sense.
// - Register-pair path, even parity generated.
// - Port A driven only while its enable.
// - Sense low gives even A-to-B parity.
`timescale 1ns/1ps
module bpr_core (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Port A pins (memory side)
  input  wire logic [bpr_pkg::WORD_W-1:0]    aIn,
  input  wire logic                          aInValid,
  output logic                               aInReady,
  output logic [bpr_pkg::WORD_W-1:0]         aOut,
  output logic                               aOe,
  // Port B pins (processor side)
  input  wire logic [bpr_pkg::WORD_W-1:0]    bIn,
  output logic [bpr_pkg::WORD_W-1:0]         bOut,
  output logic                               bOe,
  // Direction controls
  input  wire logic                          clkEnAb,
  input  wire logic                          clkEnBa,
  input  wire logic                          outEnA,
  input  wire logic                          outEnB,
  input  wire logic                          paritySense,
  input  wire logic                          pathSel,
  input  wire logic                          latchEn,
  // Status
  output logic                               aSideParityError,
  output logic                               bSideParityError
);
  import bpr_pkg::*;

  // ==========================================================================
  // Helpers
  // Parity bit for eight data bits; sense low gives even, high gives odd.
  function automatic logic genPar(input logic [DATA_W-1:0] d, input logic sense);
    return (^d) ^ sense;
  endfunction

  // True when a nine-bit word fails the even check.
  function automatic logic evenFails(input logic [WORD_W-1:0] w);
    return ^w;
  endfunction

  function automatic bpr_path_t pathOf(input logic sel);
    return (sel == SEL_LATCH_PATH) ? BPR_PATH_LATCH : BPR_PATH_PIPE;
  endfunction

  // ==========================================================================
  // Input FIFO on port A
  logic [WORD_W-1:0] fifoHead;
  logic              fifoValid;
  logic              fifoPop;

  // The holding register only drains the FIFO on an enabled edge, so a
  // disabled A-to-B direction fills the FIFO and stalls the source.
  assign fifoPop = clkEnAb;

  bpr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (aIn),
    .inValid  (aInValid),
    .inReady  (aInReady),
    .outData  (fifoHead),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // ==========================================================================
  // A-to-B direction
  logic [WORD_W-1:0] x_q, x_d;
  logic              a_side_parity_error_q, a_side_parity_error_d;
  logic              bOe_q, bOe_d;
  logic              abLoad;

  // Capture data with generated parity; flag a failed even check.
  always_comb begin
    abLoad  = clkEnAb && fifoValid;
    x_d     = x_q;
    a_side_parity_error_d = a_side_parity_error_q;
    if (abLoad) begin
      x_d[DATA_W-1:0] = fifoHead[DATA_W-1:0];
      x_d[PAR_BIT]    = genPar(fifoHead[DATA_W-1:0], paritySense);
      a_side_parity_error_d         = evenFails(fifoHead);
    end
    bOe_d = outEnB;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      x_q     <= WORD_RST;
      a_side_parity_error_q <= 1'b0;
      bOe_q   <= 1'b0;
    end else begin
      x_q     <= x_d;
      a_side_parity_error_q <= a_side_parity_error_d;
      bOe_q   <= bOe_d;
    end
  end

  // ==========================================================================
  // B-to-A direction
  logic [WORD_W-1:0] w_q, w_d, y_q, y_d, z_q, z_d;
  logic [WORD_W-1:0] wView, path1Word, path2Word;
  logic              b_side_parity_error_q, b_side_parity_error_d;
  logic              aOe_q, aOe_d;
  logic              latchParityBit;
  bpr_path_t         pathNow;

  // The latch is modelled as a flop plus a bypass, giving true transparency
  // without an inferred latch; it runs regardless of the clock enables.
  always_comb begin
    w_d            = latchEn ? bIn : w_q;
    wView          = latchEn ? bIn : w_q;
    latchParityBit = wView[PAR_BIT] ^ paritySense;
    path1Word      = {latchParityBit, wView[DATA_W-1:0]};
    path2Word      = {genPar(y_q[DATA_W-1:0], SENSE_EVEN), y_q[DATA_W-1:0]};
    pathNow        = pathOf(pathSel);
    y_d            = y_q;
    z_d            = z_q;
    b_side_parity_error_d        = b_side_parity_error_q;
    if (clkEnBa) begin
      y_d = bIn;
      case (pathNow)
        BPR_PATH_LATCH: begin
          z_d     = path1Word;
          b_side_parity_error_d = evenFails(wView);
        end
        BPR_PATH_PIPE: begin
          z_d     = path2Word;
          b_side_parity_error_d = evenFails(y_q);
        end
        default: begin
          z_d     = z_q;
          b_side_parity_error_d = b_side_parity_error_q;
        end
      endcase
    end
    aOe_d = outEnA;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_q     <= WORD_RST;
      y_q     <= WORD_RST;
      z_q     <= WORD_RST;
      b_side_parity_error_q <= 1'b0;
      aOe_q   <= 1'b0;
    end else begin
      w_q     <= w_d;
      y_q     <= y_d;
      z_q     <= z_d;
      b_side_parity_error_q <= b_side_parity_error_d;
      aOe_q   <= aOe_d;
    end
  end

  // ==========================================================================
  // Pin outputs
  // Data lines always carry the register; the enables decide who drives.
  assign bOut             = x_q;
  assign bOe              = bOe_q;
  assign aOut             = z_q;
  assign aOe              = aOe_q;
  assign aSideParityError = a_side_parity_error_q;
  assign bSideParityError = b_side_parity_error_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_x_load_data: assert property (
    abLoad |=> bOut[DATA_W-1:0] == $past(fifoHead[DATA_W-1:0]))
    else $error("A-to-B register did not capture the FIFO head.");

  chk_x_par_sense: assert property (
    abLoad |=> (^bOut) == $past(paritySense))
    else $error("A-to-B parity does not follow the sense control.");

  chk_x_even_low: assert property (
    abLoad && !paritySense |=> !(^bOut))
    else $error("Sense low did not give even A-to-B parity.");

  chk_a_err_flag: assert property (
    abLoad |=> aSideParityError == $past(^fifoHead))
    else $error("Port-A parity error flag is wrong.");

  chk_x_hold_off: assert property (
    !clkEnAb |=> $stable(bOut) && $stable(aSideParityError))
    else $error("A-to-B register changed with its enable low.");

  chk_oe_follow: assert property (
    ##1 (bOe == $past(outEnB)) && (aOe == $past(outEnA)))
    else $error("Output enables do not follow their controls.");

  // A quiet A-to-B direction with outEnB high must leave port B driven with unchanged data.
  chk_b_oe_drive: assert property (
    outEnB && !clkEnAb |=> bOe && $stable(bOut))
    else $error("Port B not driven while enabled.");

  chk_z_latch_path: assert property (
    clkEnBa && pathSel == SEL_LATCH_PATH
      |=> aOut == {$past(bIn[PAR_BIT] ^ paritySense) && $past(latchEn)
                   || $past(w_q[PAR_BIT] ^ paritySense) && !$past(latchEn),
                   $past(wView[DATA_W-1:0])})
    else $error("Latch path word reached port A wrongly.");

  chk_z_pipe_two: assert property (
    clkEnBa ##1 (clkEnBa && pathSel != SEL_LATCH_PATH)
      |=> aOut[DATA_W-1:0] == $past(bIn[DATA_W-1:0], 2) && !(^aOut))
    else $error("Register-pair path is not two deep with even parity.");

  chk_b_err_flag: assert property (
    clkEnBa |=> bSideParityError == $past(pathSel == SEL_LATCH_PATH ? ^wView : ^y_q))
    else $error("Port-B parity error flag is wrong.");

  chk_z_hold_off: assert property (
    !clkEnBa |=> $stable(aOut) && $stable(bSideParityError))
    else $error("B-to-A output changed with its enable low.");

  chk_latch_hold: assert property (
    !latchEn |=> $stable(w_q))
    else $error("Latch changed while closed.");

  chk_a_oe_drive: assert property (
    !outEnA |=> !aOe)
    else $error("Port A driven while its enable is low.");

  chk_total_even: assert property (
    abLoad && !paritySense ##1 clkEnBa && latchEn && !paritySense && bIn == bOut
      |=> !(^aOut) || pathSel != SEL_LATCH_PATH)
    else $error("Even parity loop-back failed.");

  cov_latch_path: cover property (clkEnBa && pathSel == SEL_LATCH_PATH ##1 aOe);
  cov_pipe_path:  cover property (clkEnBa && pathSel != SEL_LATCH_PATH ##1 clkEnBa ##1 aOe);
  cov_a_error:    cover property (abLoad ##1 aSideParityError);
  cov_stall:      cover property (aInValid && !aInReady);

  // ==========================================================================
  // Further checks on the enables and the inner registers
  // Each enable pin is checked in both senses, so a stuck flop shows at once.
  chk_b_oe_on: assert property (
    outEnB |=> bOe)
    else $error("Port B enable did not rise after its control.");

  chk_b_oe_off: assert property (
    !outEnB |=> !bOe)
    else $error("Port B driven while its enable is low.");

  chk_a_oe_on: assert property (
    outEnA |=> aOe)
    else $error("Port A enable did not rise after its control.");

  // An enabled edge with an empty FIFO must not disturb the holding register.
  chk_pop_empty: assert property (
    clkEnAb && !fifoValid |=> $stable(bOut) && $stable(aSideParityError))
    else $error("A-to-B register moved with no word to take.");

  // The error flag only reflects a word that was actually loaded.
  chk_a_err_hold: assert property (
    !abLoad |=> $stable(aSideParityError))
    else $error("Port-A parity error flag moved without a load.");

  // An open latch follows the pins on every edge, whatever the clock enables.
  chk_latch_open: assert property (
    latchEn |=> w_q == $past(bIn))
    else $error("Open latch did not follow port B.");

  // The first stage of the register pair loads on every enabled edge.
  chk_y_load: assert property (
    clkEnBa |=> y_q == $past(bIn))
    else $error("First pair register did not load port B.");

  chk_y_hold: assert property (
    !clkEnBa |=> $stable(y_q))
    else $error("First pair register changed with its enable low.");

  // The path choice is one-hot; anything else would leave Z frozen silently.
  chk_path_onehot: assert property (
    $onehot(pathNow))
    else $error("Path choice is not one-hot.");
endmodule

// File: tb/bpr_mem_model.sv
// Memory-side model that offers words to port A and holds each one until it is taken or 64 falling edges pass.
`timescale 1ns/1ps
module bpr_mem_model (
  // Clock
  input  wire logic                       clk,
  // Fill handshake
  input  wire logic                       aInReady,
  output logic [bpr_pkg::WORD_W-1:0]      aIn,
  output logic                            aInValid
);
  import bpr_pkg::*;

  bit stuck;

  // Lines idle low at time zero, before any offer.
  initial begin
    aIn = WORD_RST;
    aInValid = 1'b0;
    stuck = 1'b0;
  end

  // Ready is looked at on the falling edge, so the rising edge that follows is the one that takes the word.
  task automatic push(input logic [WORD_W-1:0] w);
    int n;
    aIn <= w;
    aInValid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      if (aInReady === 1'b1) break;
    end
    if (n == 64) stuck = 1'b1;
    @(posedge clk);
  endtask

  // A released bus shows the inverse of its last word, so stale data cannot pass for fresh.
  task automatic idle();
    aInValid <= 1'b0;
    aIn <= ~aIn;
  endtask
endmodule

// File: tb/bidir_parity_register_bench.sv
// Self-checking bench for the bidirectional parity register.
`timescale 1ns/1ps
module bidir_parity_register_bench;
  import bpr_pkg::*;

  // ==========================================================================
  // Signals
  logic              clk, rst, aInValid, aInReady, aOe, bOe, clkEnAb, clkEnBa;
  logic              outEnA, outEnB, paritySense, pathSel, latchEn;
  logic              aSideParityError, bSideParityError;
  logic [WORD_W-1:0] aIn, aOut, bIn, bOut;
  int                miscompares, checksDone;
  // Each row is {kind, sense, word}: kind 0 is A to B, 1 the latch path, 2 the register pair.
  logic [11:0]       rows [8];

  bpr_core uut (.clk(clk), .rst(rst), .aIn(aIn), .aInValid(aInValid), .aInReady(aInReady),
    .aOut(aOut), .aOe(aOe), .bIn(bIn), .bOut(bOut), .bOe(bOe), .clkEnAb(clkEnAb),
    .clkEnBa(clkEnBa), .outEnA(outEnA), .outEnB(outEnB), .paritySense(paritySense),
    .pathSel(pathSel), .latchEn(latchEn), .aSideParityError(aSideParityError),
    .bSideParityError(bSideParityError));

  bpr_mem_model mem (.clk(clk), .aInReady(aInReady), .aIn(aIn), .aInValid(aInValid));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The full run needs well under a thousand cycles, so three thousand means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    summarize();
  end

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [WORD_W-1:0] w, e;
    logic              s;
    logic [1:0]        k;
    rows = '{{2'h0, 1'h0, 9'h0a5}, {2'h0, 1'h1, 9'h1a5}, {2'h0, 1'h0, 9'h107}, {2'h1, 1'h0, 9'h155},
             {2'h1, 1'h1, 9'h0ff}, {2'h1, 1'h1, 9'h181}, {2'h2, 1'h0, 9'h03c}, {2'h2, 1'h1, 9'h1c3}};
    {rst, clkEnAb, clkEnBa, outEnA, outEnB, paritySense, pathSel, latchEn} = 8'h80;
    bIn = 9'h000;
    miscompares = 0;
    checksDone = 0;
    repeat (10) @(posedge clk);
    #1;
    chk({8'h00, aInReady}, 9'h000);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(aOut | bOut, WORD_RST);
    chk({aOe, bOe, aSideParityError, bSideParityError, aInReady, 4'h0}, 9'h010);
    // Each enable shows at its pin one edge later, and the two never track each other.
    @(posedge clk);
    outEnA <= 1'b1;
    @(posedge clk);
    outEnA <= 1'b0;
    outEnB <= 1'b1;
    #1;
    chk({7'h00, aOe, bOe}, 9'h002);
    @(posedge clk);
    outEnB <= 1'b0;
    #1;
    chk({7'h00, aOe, bOe}, 9'h001);
    // Ordinary transfers, one row at a time.
    for (int i = 0; i < 8; i++) begin
      w = rows[i][8:0];
      s = rows[i][9];
      k = rows[i][11:10];
      @(posedge clk);
      case (k)
        2'h0: begin
          mem.push(w);
          mem.idle();
          @(posedge clk);
          clkEnAb <= 1'b1;
          paritySense <= s;
          @(posedge clk);
          clkEnAb <= 1'b0;
          e = {^w[7:0] ^ s, w[7:0]};
        end
        2'h1: begin
          bIn <= w;
          latchEn <= 1'b1;
          pathSel <= SEL_LATCH_PATH;
          paritySense <= s;
          clkEnBa <= 1'b1;
          @(posedge clk);
          clkEnBa <= 1'b0;
          e = {w[8] ^ s, w[7:0]};
        end
        default: begin
          bIn <= w;
          pathSel <= ~SEL_LATCH_PATH;
          paritySense <= s;
          clkEnBa <= 1'b1;
          @(posedge clk);
          bIn <= ~w;
          @(posedge clk);
          clkEnBa <= 1'b0;
          e = {^w[7:0], w[7:0]};
        end
      endcase
      #1;
      chk(k == 2'h0 ? bOut : aOut, e);
      chk({8'h00, k == 2'h0 ? aSideParityError : bSideParityError}, {8'h00, ^w});
    end
    // The closed latch must keep its word while the pins move on.
    @(posedge clk);
    bIn <= 9'h1e1;
    latchEn <= 1'b1;
    paritySense <= SENSE_EVEN;
    pathSel <= SEL_LATCH_PATH;
    @(posedge clk);
    latchEn <= 1'b0;
    bIn <= 9'h00f;
    clkEnBa <= 1'b1;
    @(posedge clk);
    clkEnBa <= 1'b0;
    bIn <= 9'h0f0;
    #1;
    chk(aOut, 9'h1e1);
    chk({8'h00, bSideParityError}, 9'h001);
    @(posedge clk);
    #1;
    chk(aOut, 9'h1e1);
    // Fill the FIFO until it refuses, then drain it back to back and pop once more while empty.
    @(posedge clk);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      mem.push(9'(i * 37 + 5));
    end
    mem.idle();
    @(negedge clk);
    chk({8'h00, aInReady}, 9'h000);
    @(posedge clk);
    clkEnAb <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      @(posedge clk);
      #1;
      w = 9'(i * 37 + 5);
      chk(bOut, {^w[7:0], w[7:0]});
    end
    @(posedge clk);
    clkEnAb <= 1'b0;
    #1;
    chk(bOut, {^w[7:0], w[7:0]});
    chk({7'h00, aInReady, mem.stuck}, 9'h002);
    summarize();
  end
endmodule
